/* sdro_readout.sv */
// Three channel sigma-delta decimation readout with register port.
// Assumes synchronous modulator bits sampled on the modulator tick and a
// register master that never issues read and write in the same cycle.
//
// Behaviour
// - Each channel averages its one-bit modulator stream.
// - Filter is a third-order comb, sinc cubed.
// - One result per ratio modulator cycles per channel.
// - Source, divider and ratio set sample rate.
// - Pair and gain changes apply at decimation, at once when the channel is idle.
// - Delay zero suppresses interrupts until fourth conversion.
// - Filter output spans fifteen to twenty-four bits.
// - Ratio 256 shows filter bits 23 to 8.
// - Ratio 32 result bit zero reads zero.
// - Low access word read returns sixteen low bits.
// - Byte read returns eight low filter bits.
// - Toggle mode inverts low access on reads.
// - Writing toggle also loads low access from its own bit.
// - New result sets the result flag.
// - Result read or software write of zero clears flag.
// - Converter powers down when nothing converts.
// - Reference follows only its own control.
// - Reference driven out only when buffer set.
// - External reference accepted when both controls clear.
// - Eight pairs; six temperature, seven shorted.
// - Six gain settings, one through thirty-two.
// - Each channel holds its own input configuration.
// - Format bit picks offset binary or two's complement.
// - Single mode clears start after conversion.
// - Three channels, each with filter, result, flag.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "sdro_regs.svh"

module sdro_readout
	import sdro_pkg::*;
(
	// Clock and reset.
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	// Register port.
	input  wire logic [7:0]           reg_addr,
	input  wire logic [15:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	input  wire logic                 reg_byte,
	output wire logic [15:0]          reg_rdata,
	// Modulator side.
	input  wire logic                 aux_clk_tick,
	input  wire logic [2:0]           mod_bit,
	output wire logic                 mod_clk_tick,
	output wire logic [2:0]           mod_enable,
	output wire logic [2:0][2:0]      input_pair_sel,
	output wire logic [2:0][2:0]      pga_gain_sel,
	output wire logic [2:0]           temp_sensor_route,
	output wire logic [2:0]           input_short,
	// Power and reference.
	output wire logic                 converter_power_on,
	output wire logic                 ref_power_on,
	output wire logic                 ref_out_drive,
	output wire logic                 ext_ref_accept,
	// Interrupt requests per channel.
	output wire logic [2:0]           irq_req
);

	// ****************************************************************
	// State and decoded helpers
	// ****************************************************************
	sdro_state_s      st_ff;      // Registered state.
	sdro_state_s      nxt_st;     // Next state.
	logic             tick;       // Modulator clock enable pulse.
	logic [2:0]       dec_hit;    // Decimation step of each channel.
	logic [2:0]       settled;    // Settling delay expired per channel.
	logic [2:0][23:0] fmt_raw;    // Formatted right aligned filter output.
	logic [2:0][23:0] aligned;    // Output with its top bit at bit 23.
	logic [2:0]       res_rd;     // Result register read per channel.

	// Sample rate divider tick and per channel formatting.
	always_comb begin
		logic [4:0] width;
		logic [7:0] div_top;
		width   = 5'h00;
		div_top = (8'h01 << st_ff.mod_clk_div) - 8'h01;
		// Source zero is the system clock, any other is the auxiliary tick.
		tick = ((st_ff.mod_clk_src_sel == 2'b00) || aux_clk_tick) &&
			(st_ff.div_cnt == div_top);
		for (int c = 0; c < SDRO_NCH; c++) begin
			// Output width is three bits per octave of ratio.
			width = 5'h18 - 5'(3 * int'(st_ff.osr[c]));
			dec_hit[c] = tick && st_ff.start_conversion[c] &&
				(st_ff.dec_cnt[c] == ((8'hFF >> st_ff.osr[c])));
			// Two's complement flips the top bit of the output word.
			fmt_raw[c] = st_ff.filt[c] ^
				({23'h000000, st_ff.data_format_sel[c]} << (width - 5'h01));
			// Align so that ratio 256 puts bits 23..8 in the result.
			aligned[c] = fmt_raw[c] << (`SDRO_FULL_BITS - width);
			settled[c] = st_ff.conv_cnt[c] >=
				(`SDRO_SETTLE_CONV - {1'b0, st_ff.irq_settle_delay[c]});
			res_rd[c] = reg_rd && (reg_addr == (`SDRO_OFS_RES0 + 8'(c)));
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic [24:0] c1;
		logic [24:0] c2;
		logic [24:0] c3;
		logic [24:0] ni3;
		logic [23:0] full;
		c1     = 25'h0000000;
		c2     = 25'h0000000;
		c3     = 25'h0000000;
		ni3    = 25'h0000000;
		full   = 24'h000000;
		nxt_st = st_ff;
		// Divider counts source ticks and wraps at the modulator tick.
		if (tick) begin
			nxt_st.div_cnt = 8'h00;
		end else if ((st_ff.mod_clk_src_sel == 2'b00) || aux_clk_tick) begin
			nxt_st.div_cnt = st_ff.div_cnt + 8'h01;
		end
		for (int c = 0; c < SDRO_NCH; c++) begin
			full = (24'h000001 << (`SDRO_FULL_BITS - 5'(3 * int'(st_ff.osr[c]))))
				- 24'h000001;
			if (!st_ff.start_conversion[c]) begin
				// Idle channel: filter off and inputs follow software.
				nxt_st.i1[c]       = 25'h0000000;
				nxt_st.i2[c]       = 25'h0000000;
				nxt_st.i3[c]       = 25'h0000000;
				nxt_st.d1[c]       = 25'h0000000;
				nxt_st.d2[c]       = 25'h0000000;
				nxt_st.d3[c]       = 25'h0000000;
				nxt_st.dec_cnt[c]  = 8'h00;
				nxt_st.pair_act[c] = st_ff.pair_sw[c];
				nxt_st.gain_act[c] = st_ff.gain_sw[c];
			end else if (tick) begin
				// Three cascaded integrators average the bit stream.
				nxt_st.i1[c] = st_ff.i1[c] + {24'h000000, mod_bit[c]};
				nxt_st.i2[c] = st_ff.i2[c] + nxt_st.i1[c];
				ni3          = st_ff.i3[c] + nxt_st.i2[c];
				nxt_st.i3[c] = ni3;
				nxt_st.dec_cnt[c] = st_ff.dec_cnt[c] + 8'h01;
				if (dec_hit[c]) begin
					// Three combs run once per ratio ticks.
					c1 = ni3 - st_ff.d1[c];
					c2 = c1 - st_ff.d2[c];
					c3 = c2 - st_ff.d3[c];
					nxt_st.d1[c] = ni3;
					nxt_st.d2[c] = c1;
					nxt_st.d3[c] = c2;
					nxt_st.dec_cnt[c] = 8'h00;
					// A full scale stream is clipped to the output width.
					nxt_st.filt[c] = (c3 > {1'b0, full}) ? full : c3[23:0];
					nxt_st.result_ready_flag[c] = 1'b1;
					if (st_ff.conv_cnt[c] != `SDRO_SETTLE_CONV) begin
						nxt_st.conv_cnt[c] = st_ff.conv_cnt[c] + 3'h1;
					end
					// New pair and gain only at the decimation step.
					nxt_st.pair_act[c] = st_ff.pair_sw[c];
					nxt_st.gain_act[c] = st_ff.gain_sw[c];
					// Single mode ends with the first settled result.
					if (st_ff.single[c] && (st_ff.conv_cnt[c] + 3'h1 >=
						(`SDRO_SETTLE_CONV - {1'b0, st_ff.irq_settle_delay[c]}))) begin
						nxt_st.start_conversion[c] = 1'b0;
					end
				end
			end
		end
		// Register writes.
		if (reg_wr) begin
			if (reg_addr == `SDRO_OFS_GLOBAL) begin
				nxt_st.ref_on            = reg_wdata[`SDRO_G_REF_ON];
				nxt_st.ref_out_buffer_on = reg_wdata[`SDRO_G_REF_BUF];
				nxt_st.mod_clk_src_sel   = reg_wdata[`SDRO_G_SRC_LO +: 2];
				nxt_st.mod_clk_div       = reg_wdata[`SDRO_G_DIV_LO +: 2];
				nxt_st.div_cnt           = 8'h00;
			end
			if (reg_addr == `SDRO_OFS_IEN) begin
				nxt_st.ien = reg_wdata[2:0];
			end
			for (int c = 0; c < SDRO_NCH; c++) begin
				// Software clears a flag by writing zero; a new result wins.
				if ((reg_addr == `SDRO_OFS_FLAGS) && !dec_hit[c]) begin
					nxt_st.result_ready_flag[c] = reg_wdata[c];
				end
				if (reg_addr == (`SDRO_OFS_CTL0 + 8'(c))) begin
					// A start condition restarts the settling count, so a request
					// of a restarted channel stays down until it settles again.
					if (!st_ff.start_conversion[c] && reg_wdata[`SDRO_C_START]) begin
						nxt_st.conv_cnt[c] = 3'h0;
					end
					nxt_st.start_conversion[c]     = reg_wdata[`SDRO_C_START];
					nxt_st.single[c]               = reg_wdata[`SDRO_C_SINGLE];
					nxt_st.low_bits_access[c]      = reg_wdata[`SDRO_C_LOW_BITS_ACCESS_SHORT];
					// Toggle control is stored; low access takes its bit of the same write.
					nxt_st.low_bits_auto_toggle[c] = reg_wdata[`SDRO_C_LSBTOG];
					nxt_st.data_format_sel[c]      = reg_wdata[`SDRO_C_DFMT];
					nxt_st.osr[c]                  = reg_wdata[`SDRO_C_OSR_LO +: 2];
					nxt_st.irq_settle_delay[c]     = reg_wdata[`SDRO_C_DLY_LO +: 2];
				end
				// Each channel keeps its own input configuration.
				if (reg_addr == (`SDRO_OFS_INCTL0 + 8'(c))) begin
					nxt_st.pair_sw[c] = reg_wdata[`SDRO_I_PAIR_LO +: 3];
					// Codes above the sixth gain clamp to gain 32.
					nxt_st.gain_sw[c] = (reg_wdata[`SDRO_I_GAIN_LO +: 3] > `SDRO_GAIN_MAX) ?
						`SDRO_GAIN_MAX : reg_wdata[`SDRO_I_GAIN_LO +: 3];
				end
			end
		end
		// Register reads, answered in the next cycle.
		nxt_st.rd_data = `SDRO_RST_16;
		if (reg_rd) begin
			case (reg_addr)
				`SDRO_OFS_GLOBAL: begin
					nxt_st.rd_data = {10'h000, st_ff.mod_clk_div, st_ff.mod_clk_src_sel,
						st_ff.ref_out_buffer_on, st_ff.ref_on};
				end
				`SDRO_OFS_FLAGS: begin
					nxt_st.rd_data = {13'h0000, st_ff.result_ready_flag};
				end
				`SDRO_OFS_IEN: begin
					nxt_st.rd_data = {13'h0000, st_ff.ien};
				end
				default: begin
					nxt_st.rd_data = `SDRO_RST_16;
				end
			endcase
			for (int c = 0; c < SDRO_NCH; c++) begin
				if (reg_addr == (`SDRO_OFS_CTL0 + 8'(c))) begin
					nxt_st.rd_data = {7'h00, st_ff.irq_settle_delay[c], st_ff.osr[c],
						st_ff.data_format_sel[c], st_ff.low_bits_auto_toggle[c],
						st_ff.low_bits_access[c], st_ff.single[c],
						st_ff.start_conversion[c]};
				end
				if (reg_addr == (`SDRO_OFS_INCTL0 + 8'(c))) begin
					nxt_st.rd_data = {10'h000, st_ff.gain_sw[c], st_ff.pair_sw[c]};
				end
				if (res_rd[c]) begin
					if (reg_byte) begin
						nxt_st.rd_data = {8'h00, fmt_raw[c][7:0]};
					end else if (st_ff.low_bits_access[c]) begin
						nxt_st.rd_data = fmt_raw[c][15:0];
					end else begin
						// Ratio 32 leaves bit zero empty after alignment.
						nxt_st.rd_data = aligned[c][23:8];
					end
					// Read clears the flag unless a result lands now.
					if (!dec_hit[c]) begin
						nxt_st.result_ready_flag[c] = 1'b0;
					end
					if (st_ff.low_bits_auto_toggle[c]) begin
						nxt_st.low_bits_access[c] = !st_ff.low_bits_access[c];
					end
				end
			end
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			nxt_st_reset();
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Reset clears the whole state; all controls start off.
	task automatic nxt_st_reset();
		st_ff <= '0;
	endtask

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign reg_rdata          = st_ff.rd_data;
	assign mod_clk_tick       = tick;
	assign mod_enable         = st_ff.start_conversion;
	assign input_pair_sel     = st_ff.pair_act;
	assign pga_gain_sel       = st_ff.gain_act;
	// Converter powers up whenever any channel runs.
	assign converter_power_on = |st_ff.start_conversion;
	// Reference has no automatic power-down.
	assign ref_power_on       = st_ff.ref_on;
	assign ref_out_drive      = st_ff.ref_out_buffer_on;
	assign ext_ref_accept     = !st_ff.ref_on && !st_ff.ref_out_buffer_on;

	// Pair decode for the analog multiplexer; outputs are nets, so continuous.
	for (genvar g = 0; g < SDRO_NCH; g++) begin : g_dec
		assign temp_sensor_route[g] = st_ff.pair_act[g] == `SDRO_PAIR_TEMP;
		assign input_short[g]       = st_ff.pair_act[g] == `SDRO_PAIR_SHORT;
		// Flag raises a request only once enabled and settled.
		assign irq_req[g]           = st_ff.result_ready_flag[g] && st_ff.ien[g] && settled[g];
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	sequence s_res0_read;
		reg_rd && (reg_addr == `SDRO_OFS_RES0) && !reg_byte;
	endsequence

	property p_flag_set;
		@(posedge clk_sys) disable iff (!rstn)
		dec_hit[0] |=> st_ff.result_ready_flag[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set by result");

	property p_flag_rd_clr;
		@(posedge clk_sys) disable iff (!rstn)
		reg_rd && (reg_addr == `SDRO_OFS_RES0) && !dec_hit[0] |=> !st_ff.result_ready_flag[0];
	endproperty
	a_flag_rd_clr: assert property (p_flag_rd_clr) else $error("flag kept after read");

	property p_toggle;
		@(posedge clk_sys) disable iff (!rstn)
		s_res0_read ##0 st_ff.low_bits_auto_toggle[0] |=>
			st_ff.low_bits_access[0] != $past(st_ff.low_bits_access[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("low access not toggled");

	property p_low_word;
		@(posedge clk_sys) disable iff (!rstn)
		s_res0_read ##0 st_ff.low_bits_access[0] |=> reg_rdata == $past(fmt_raw[0][15:0]);
	endproperty
	a_low_word: assert property (p_low_word) else $error("low word mismatch");

	property p_osr32_lsb;
		@(posedge clk_sys) disable iff (!rstn)
		s_res0_read ##0 (!st_ff.low_bits_access[0] && st_ff.osr[0] == SDRO_OSR_32)
			|=> !reg_rdata[0];
	endproperty
	a_osr32_lsb: assert property (p_osr32_lsb) else $error("ratio 32 bit zero set");

	property p_irq_delay;
		@(posedge clk_sys) disable iff (!rstn)
		irq_req[1] && (st_ff.irq_settle_delay[1] == 2'b00) |-> st_ff.conv_cnt[1] == 3'h4;
	endproperty
	a_irq_delay: assert property (p_irq_delay) else $error("early interrupt");

	property p_pair_hold;
		@(posedge clk_sys) disable iff (!rstn)
		$changed(st_ff.pair_act[0]) |-> $past(dec_hit[0] || !st_ff.start_conversion[0]);
	endproperty
	a_pair_hold: assert property (p_pair_hold) else $error("pair changed mid step");

	property p_single_end;
		@(posedge clk_sys) disable iff (!rstn)
		dec_hit[1] && st_ff.single[1] && (st_ff.conv_cnt[1] == 3'h3) &&
			(st_ff.irq_settle_delay[1] == 2'b00) && !reg_wr |=> !st_ff.start_conversion[1];
	endproperty
	a_single_end: assert property (p_single_end) else $error("single run not ended");

	property p_power;
		@(posedge clk_sys) disable iff (!rstn)
		reg_wr && (reg_addr == `SDRO_OFS_CTL0) && reg_wdata[0] |=> ##1 converter_power_on;
	endproperty
	a_power: assert property (p_power) else $error("converter not powered");

endmodule

/* sdro_regs.svh */
// Register offsets, field positions, reset values and counts of the decimation readout.
// Assumes a plain register port with 8-bit word addresses and 16-bit data.
`ifndef SDRO_REGS_SVH
`define SDRO_REGS_SVH

// ****************************************************************
// Register offsets (word addresses)
// ****************************************************************
`define SDRO_OFS_GLOBAL   8'h00
`define SDRO_OFS_FLAGS    8'h08
`define SDRO_OFS_IEN      8'h09
`define SDRO_OFS_CTL0     8'h10
`define SDRO_OFS_INCTL0   8'h18
`define SDRO_OFS_RES0     8'h20

// ****************************************************************
// Global control field positions
// ****************************************************************
`define SDRO_G_REF_ON     0
`define SDRO_G_REF_BUF    1
`define SDRO_G_SRC_LO     2
`define SDRO_G_DIV_LO     4

// ****************************************************************
// Channel control field positions
// ****************************************************************
`define SDRO_C_START      0
`define SDRO_C_SINGLE     1
`define SDRO_C_LOW_BITS_ACCESS_SHORT     2
`define SDRO_C_LSBTOG     3
`define SDRO_C_DFMT       4
`define SDRO_C_OSR_LO     5
`define SDRO_C_DLY_LO     7

// ****************************************************************
// Input control field positions and limits
// ****************************************************************
`define SDRO_I_PAIR_LO    0
`define SDRO_I_GAIN_LO    3
`define SDRO_GAIN_MAX     3'h5
`define SDRO_PAIR_TEMP    3'h6
`define SDRO_PAIR_SHORT   3'h7

// ****************************************************************
// Counts and reset values
// ****************************************************************
`define SDRO_SETTLE_CONV  3'h4
`define SDRO_FULL_BITS    5'h18
`define SDRO_RST_16       16'h0000

`endif

/* sdro_pkg.sv */
// Types shared by the decimation readout.
// Assumes the constants header is compiled alongside.
package sdro_pkg;

	// Number of converter channels.
	localparam int SDRO_NCH = 3;

	// Oversampling ratio codes.
	typedef enum logic [1:0] {
		SDRO_OSR_256 = 2'b00,
		SDRO_OSR_128 = 2'b01,
		SDRO_OSR_64  = 2'b10,
		SDRO_OSR_32  = 2'b11
	} sdro_osr_e;

	// Whole state of the readout block.
	typedef struct packed {
		logic                       ref_on;               // Reference power control.
		logic                       ref_out_buffer_on;    // Reference output buffer control.
		logic [1:0]                 mod_clk_src_sel;      // Modulator clock source.
		logic [1:0]                 mod_clk_div;          // Modulator clock divider code.
		logic [7:0]                 div_cnt;              // Divider counter.
		logic [2:0]                 start_conversion;     // Per channel run bits.
		logic [2:0]                 single;               // Per channel single mode.
		logic [2:0]                 low_bits_access;      // Per channel low-bit access.
		logic [2:0]                 low_bits_auto_toggle; // Per channel toggle control.
		logic [2:0]                 data_format_sel;      // Per channel two's complement.
		logic [2:0][1:0]            osr;                  // Per channel ratio code.
		logic [2:0][1:0]            irq_settle_delay;     // Per channel settle field.
		logic [2:0][2:0]            pair_sw;              // Software pair selection.
		logic [2:0][2:0]            gain_sw;              // Software gain selection.
		logic [2:0][2:0]            pair_act;             // Pair in use by the modulator.
		logic [2:0][2:0]            gain_act;             // Gain in use by the modulator.
		logic [2:0]                 ien;                  // Per channel interrupt enable.
		logic [2:0]                 result_ready_flag;    // Per channel result flag.
		logic [2:0][24:0]           i1;                   // First integrators.
		logic [2:0][24:0]           i2;                   // Second integrators.
		logic [2:0][24:0]           i3;                   // Third integrators.
		logic [2:0][24:0]           d1;                   // First comb delays.
		logic [2:0][24:0]           d2;                   // Second comb delays.
		logic [2:0][24:0]           d3;                   // Third comb delays.
		logic [2:0][7:0]            dec_cnt;              // Decimation counters.
		logic [2:0][2:0]            conv_cnt;             // Conversions since start.
		logic [2:0][23:0]           filt;                 // Right aligned filter output.
		logic [15:0]                rd_data;              // Read data register.
	} sdro_state_s;

endpackage

/* tb_sdro_readout.sv */
// Self-checking bench of the decimation readout, driving every port itself.
// Assumes a 100 MHz clk_sys and the register map of the constants header.
`timescale 1ns/100ps
`include "sdro_regs.svh"

module tb_sdro_readout;
	import sdro_pkg::*;

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic            clk_sys = 1'b0;   // System clock.
	logic            rstn = 1'b0;      // Active low reset.
	logic [7:0]      reg_addr = 8'h00; // Register address.
	logic [15:0]     reg_wdata = 16'h0000; // Write data.
	logic            reg_wr = 1'b0;    // Write strobe.
	logic            reg_rd = 1'b0;    // Read strobe.
	logic            reg_byte = 1'b0;  // Byte read qualifier.
	logic [15:0]     reg_rdata;        // Read data.
	logic            aux_clk_tick = 1'b0; // Alternate tick, kept idle.
	logic [2:0]      mod_bit = 3'h0;   // Modulator bits.
	logic            mod_clk_tick;
	logic [2:0]      mod_enable, temp_sensor_route, input_short, irq_req;
	logic [2:0][2:0] input_pair_sel, pga_gain_sel;
	logic            converter_power_on, ref_power_on, ref_out_drive, ext_ref_accept;
	logic [1:0]      pat = 2'h0;       // Stream pattern: 0 zeros, 1 ones, 2 alternating.
	logic [15:0]     d;                // Last read value.
	int              failures = 0;     // Mismatch count.
	int              samples_checked = 0; // Comparison count.
	int              cyc = 0;          // Cycle counter for the timeout.
	int              cyc0 = 0;         // Cycle of a conversion start.
	int              irq_at = 0;       // Cycle of the first request of channel 1.

	sdro_readout i_sdro_readout (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_byte(reg_byte),
		.reg_rdata(reg_rdata), .aux_clk_tick(aux_clk_tick), .mod_bit(mod_bit),
		.mod_clk_tick(mod_clk_tick), .mod_enable(mod_enable),
		.input_pair_sel(input_pair_sel), .pga_gain_sel(pga_gain_sel),
		.temp_sensor_route(temp_sensor_route), .input_short(input_short),
		.converter_power_on(converter_power_on), .ref_power_on(ref_power_on),
		.ref_out_drive(ref_out_drive), .ext_ref_accept(ext_ref_accept), .irq_req(irq_req));

	// ****************************************************************
	// Clock, stream, timeout and request monitor
	// ****************************************************************
	// The clock toggles every half period.
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	// The stream changes on the edge, so each tick sees a settled bit.
	always @(posedge clk_sys) begin
		mod_bit <= (pat == 2'h2) ? ~mod_bit : {3{pat[0]}};
		cyc <= cyc + 1;
		if (irq_req[1] === 1'b1 && irq_at == 0) irq_at <= cyc;
		if (cyc == 20000) begin
			failures = failures + 1;
			results();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	// Every task starts and ends just after a rising edge.
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// One-cycle write.
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		// The strobe drops on the sampling edge, so a next call may raise it again.
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask

	// One-cycle read; the data stand in the following cycle only.
	task automatic rd(input logic [7:0] a, input logic b, output logic [15:0] v);
		reg_addr <= a;
		reg_byte <= b;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_byte <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	// Compare and report.
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	// Reads a register and compares it.
	task automatic rchk(input string n, input logic [7:0] a, input logic b, input logic [15:0] e);
		logic [15:0] v;
		rd(a, b, v);
		chk(n, e, v);
	endtask

	// Waits for the result flag of channel 0, bounded.
	task automatic wflag();
		logic [15:0] v;
		v = 16'h0000;
		for (int i = 0; i < 300 && v[0] !== 1'b1; i++) rd(`SDRO_OFS_FLAGS, 1'b0, v);
		chk("flag set", 16'h0001, v & 16'h0001);
	endtask

	// Counts ticks over sixteen cycles.
	task automatic ticks(input logic [15:0] e);
		logic [15:0] n;
		n = 16'h0000;
		repeat (16) begin
			if (mod_clk_tick === 1'b1) n = n + 16'h0001;
			step(1);
		end
		chk("tick count", e, n);
	endtask

	// Prints the counts and the verdict.
	task automatic results();
		$display("compared %0d mismatched %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		step(3);
		rstn <= 1'b1;
		rchk("global rst", `SDRO_OFS_GLOBAL, 1'b0, 16'h0000);
		rchk("unmapped", 8'h7F, 1'b0, 16'h0000);
		chk("ext ref rst", 16'h0001, {15'h0, ext_ref_accept});
		$display("test reset done");
		wr(`SDRO_OFS_GLOBAL, 16'h0001);
		chk("ref on", 16'h0100, {7'h0, ref_power_on, 7'h0, ext_ref_accept});
		wr(`SDRO_OFS_GLOBAL, 16'h0003);
		chk("ref drive", 16'h0001, {15'h0, ref_out_drive});
		wr(`SDRO_OFS_GLOBAL, 16'h0000);
		chk("ref off", 16'h0001, {7'h0, ref_power_on, 7'h0, ext_ref_accept});
		wr(`SDRO_OFS_GLOBAL, 16'h0010);
		ticks(16'h0008);
		wr(`SDRO_OFS_GLOBAL, 16'h0004);
		ticks(16'h0000);
		wr(`SDRO_OFS_GLOBAL, 16'h0000);
		$display("test reference and clock done");
		pat <= 2'h1;
		wr(`SDRO_OFS_CTL0, 16'h0061);
		chk("power on", 16'h0001, {15'h0, converter_power_on});
		step(300);
		rchk("osr32 ones", `SDRO_OFS_RES0, 1'b0, 16'hFFFE);
		chk("irq masked", 16'h0000, {13'h0, irq_req});
		wr(`SDRO_OFS_CTL0, 16'h0071);
		step(300);
		rchk("twos ones", `SDRO_OFS_RES0, 1'b0, 16'h7FFE);
		pat <= 2'h2;
		step(300);
		rchk("twos zero", `SDRO_OFS_RES0, 1'b0, 16'h0000);
		wr(`SDRO_OFS_INCTL0, 16'h003E);
		chk("pair held", 16'h0000, {13'h0, input_pair_sel[0]});
		step(40);
		chk("pair now", 16'h0006, {13'h0, input_pair_sel[0]});
		chk("gain clamp", 16'h0005, {13'h0, pga_gain_sel[0]});
		chk("temp route", 16'h0001, {13'h0, temp_sensor_route});
		wr(`SDRO_OFS_INCTL0 + 8'h01, 16'h0007);
		step(2);
		chk("short ch1", 16'h0002, {13'h0, input_short});
		chk("ch1 gain", 16'h0000, {13'h0, pga_gain_sel[1]});
		wr(`SDRO_OFS_CTL0, 16'h0000);
		chk("power off", 16'h0000, {15'h0, converter_power_on});
		$display("test osr32 and inputs done");
		wr(`SDRO_OFS_CTL0, 16'h0009);
		step(1500);
		rchk("high word", `SDRO_OFS_RES0, 1'b0, 16'h8000);
		rchk("low word", `SDRO_OFS_RES0, 1'b0, 16'h0000);
		rchk("high again", `SDRO_OFS_RES0, 1'b0, 16'h8000);
		rchk("ctl toggled", `SDRO_OFS_CTL0, 1'b0, 16'h000D);
		wr(`SDRO_OFS_CTL0, 16'h0005);
		rchk("ctl kept", `SDRO_OFS_CTL0, 1'b0, 16'h0005);
		wr(`SDRO_OFS_CTL0, 16'h0001);
		rchk("byte read", `SDRO_OFS_RES0, 1'b1, 16'h0000);
		wflag();
		rd(`SDRO_OFS_RES0, 1'b0, d);
		rchk("read clears", `SDRO_OFS_FLAGS, 1'b0, 16'h0000);
		wflag();
		wr(`SDRO_OFS_FLAGS, 16'h0000);
		rchk("write clears", `SDRO_OFS_FLAGS, 1'b0, 16'h0000);
		wr(`SDRO_OFS_CTL0, 16'h0000);
		$display("test osr256 access done");
		wr(`SDRO_OFS_IEN, 16'h0002);
		cyc0 = cyc;
		wr(`SDRO_OFS_CTL0 + 8'h01, 16'h0063);
		step(200);
		chk("settle late", 16'h0001, {15'h0, (irq_at - cyc0) > 110});
		chk("settle bound", 16'h0001, {15'h0, (irq_at - cyc0) <= 140});
		rchk("single stop", `SDRO_OFS_CTL0 + 8'h01, 1'b0, 16'h0062);
		chk("idle power", 16'h0000, {12'h0, converter_power_on, mod_enable});
		$display("test settling done");
		results();
	end
endmodule
